// file: bk3_control.sv
// third buck converter control register with its bus slave and monitor blanking
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - The control register sits at offset 0x18, resets to 0xbd and reads bit 6 as zero.
// - A control write takes effect only while the unlock input is high; software unlocks first.
// - Every accepted control write hides over- and under-voltage results for 5 ms.
// - Bit 7 enables light-load pulse skipping, resets to one, and zero forces fixed frequency.
// - Bits 5 to 0 pick the voltage: 0.900 V in 25 mV steps to 1.550 V, then 50 mV steps to 3.400 V.
// - The code comes up as 0x3d (3.300 V) unless the resistor select strap picks another code.
module bk3_control #(
  parameter int unsigned BLANK_CYCLES = bk3_pkg::BK3_BLANK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // bus slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // password unlock and strap
  input wire logic writeUnlock,
  input wire logic resistorDefaultSelect,
  input wire logic [5:0] resistorDefaultCode,
  // supervisor comparators
  input wire logic overVoltageRaw,
  input wire logic underVoltageRaw,
  // converter controls
  output logic lightLoadSkipEnable,
  output logic [5:0] buck3VoltageCode,
  output logic [11:0] buck3Millivolt,
  output logic monitorBlanking,
  output logic overVoltageFault,
  output logic underVoltageFault
);
  import bk3_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    bk3_phase_e phase;
    logic dataPhase;
    logic dataWrite;
    logic [7:0] dataAddr;
    logic dataLane0;
    logic skip;
    logic [5:0] code;
    logic rejected;
    logic [7:0] writeCount;
    logic [7:0] badCount;
    logic ovQual;
    logic uvQual;
    logic [31:0] rdata;
  } bk3_control_s;

  localparam bk3_control_s STATE_RESET = '{
    phase: BK3_ST_STRAP,
    dataPhase: 1'h0,
    dataWrite: 1'h0,
    dataAddr: 8'h00,
    dataLane0: 1'h0,
    skip: BK3_CONTROL_RESET[BK3_SKIP_BIT],
    code: BK3_CONTROL_RESET[BK3_CODE_LSB +: BK3_CODE_W],
    rejected: 1'h0,
    writeCount: 8'h00,
    badCount: 8'h00,
    ovQual: 1'h0,
    uvQual: 1'h0,
    rdata: 32'h00000000
  };

  bk3_control_s state;
  bk3_control_s next_state;

  // ------------------------------------------------------------
  // local signals
  // ------------------------------------------------------------

  // bus decode results
  logic addrTaken;
  logic [7:0] addrOffset;
  logic dataLaneWrite;
  logic controlWrite;
  logic controlAccept;
  logic controlReject;
  logic statusClear;
  // blanking, monitor gate and readback
  logic blankActive;
  logic monitorOpen;
  logic [11:0] millivolt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // true for the offsets that hold a register
  function automatic logic is_mapped(input logic [7:0] ofs);
    logic hit;
    case (ofs)
      BK3_OFS_STATUS: hit = 1'h1;
      BK3_OFS_MILLIVOLT: hit = 1'h1;
      BK3_OFS_BUCK3_CONTROL: hit = 1'h1;
      default: hit = 1'h0;
    endcase
    return hit;
  endfunction

  // control register image, reserved bit always low
  function automatic logic [31:0] control_word(input logic skip, input logic [5:0] code);
    logic [31:0] word;
    word = 32'h00000000;
    word[BK3_SKIP_BIT] = skip;
    word[BK3_RSVD_BIT] = 1'h0;
    word[BK3_CODE_LSB +: BK3_CODE_W] = code;
    return word;
  endfunction

  // status register image from its live sources
  function automatic logic [31:0] status_word(input logic blank, input logic unlock,
      input logic rejected, input logic [1:0] raw, input logic [1:0] qual,
      input logic [7:0] writes, input logic [7:0] bad);
    logic [31:0] word;
    word = 32'h00000000;
    word[BK3_ST_BLANK_BIT] = blank;
    word[BK3_ST_UNLOCK_BIT] = unlock;
    word[BK3_ST_REJECT_BIT] = rejected;
    word[BK3_ST_OV_RAW_BIT] = raw[1];
    word[BK3_ST_UV_RAW_BIT] = raw[0];
    word[BK3_ST_OV_QUAL_BIT] = qual[1];
    word[BK3_ST_UV_QUAL_BIT] = qual[0];
    word[BK3_ST_WRCNT_LSB +: 8] = writes;
    word[BK3_ST_BADCNT_LSB +: 8] = bad;
    return word;
  endfunction

  // millivolt register image
  function automatic logic [31:0] millivolt_word(input logic [11:0] mv);
    logic [31:0] word;
    word = 32'h00000000;
    word[11:0] = mv;
    return word;
  endfunction

  // ------------------------------------------------------------
  // sub blocks
  // ------------------------------------------------------------

  // blanking window after accepted writes
  bk3_blank_timer #(
    .CYCLES(BLANK_CYCLES)
  ) blankTimer (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .start(controlAccept),
    .active(blankActive)
  );

  // millivolt readback of the live code
  bk3_code_decode codeDecode (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .code(state.code),
    .millivolt(millivolt)
  );

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------

  // address phase accepted only in run phase with clock enabled
  assign hreadyout = clkEn && (state.phase == BK3_ST_RUN);
  assign hresp = BK3_HRESP_OKAY;
  assign addrTaken = hsel && htrans[1] && hready;
  // upper address bits must be clear to hit a register
  assign addrOffset = (haddr[31:8] == 24'h000000) ? haddr[7:0] : BK3_OFS_UNMAPPED;

  // data-phase write strobes
  assign dataLaneWrite = state.dataPhase && state.dataWrite && state.dataLane0;
  assign controlWrite = dataLaneWrite && (state.dataAddr == BK3_OFS_BUCK3_CONTROL);
  assign controlAccept = controlWrite && writeUnlock;
  assign controlReject = controlWrite && !writeUnlock;
  assign statusClear = dataLaneWrite && (state.dataAddr == BK3_OFS_STATUS) &&
                       hwdata[BK3_ST_REJECT_BIT];

  // monitor results pass only outside the blanking window
  assign monitorOpen = !blankActive && !controlAccept;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;

    // strap capture on the first enabled cycle after reset
    case (state.phase)
      BK3_ST_STRAP: begin
        next_state.phase = BK3_ST_RUN;
        if (resistorDefaultSelect) begin
          next_state.code = resistorDefaultCode;
        end else begin
          next_state.code = BK3_CODE_RESET;
        end
      end
      BK3_ST_RUN: begin
        next_state.phase = BK3_ST_RUN;
      end
      default: begin
        next_state.phase = BK3_ST_STRAP;
      end
    endcase

    // control write, reserved bit dropped
    if (controlAccept) begin
      next_state.skip = hwdata[BK3_SKIP_BIT];
      next_state.code = hwdata[BK3_CODE_LSB +: BK3_CODE_W];
      next_state.writeCount = state.writeCount + 8'h01;
    end

    // rejected-write flag, a new rejection beats the clear
    if (controlReject) begin
      next_state.rejected = 1'h1;
    end else if (statusClear) begin
      next_state.rejected = 1'h0;
    end

    // count accesses that hit no register
    if (state.dataPhase && !is_mapped(state.dataAddr)) begin
      next_state.badCount = state.badCount + 8'h01;
    end

    // monitor results hidden while blanking runs
    next_state.ovQual = overVoltageRaw && monitorOpen;
    next_state.uvQual = underVoltageRaw && monitorOpen;

    // data phase bookkeeping
    next_state.dataPhase = 1'h0;
    next_state.dataWrite = 1'h0;
    if (addrTaken && hreadyout) begin
      next_state.dataPhase = 1'h1;
      next_state.dataWrite = hwrite;
      next_state.dataAddr = addrOffset;
      next_state.dataLane0 = bk3_lane0_hit(hsize, haddr[1:0]);
    end

    // read data: control fields, rejected flag and counts as they stand after this edge, other fields as they stand now
    next_state.rdata = 32'h00000000;
    if (addrTaken && hreadyout && !hwrite) begin
      case (addrOffset)
        BK3_OFS_BUCK3_CONTROL: begin
          next_state.rdata = control_word(next_state.skip, next_state.code);
        end
        BK3_OFS_STATUS: begin
          next_state.rdata = status_word(blankActive, writeUnlock, next_state.rejected,
            {overVoltageRaw, underVoltageRaw}, {state.ovQual, state.uvQual},
            next_state.writeCount, next_state.badCount);
        end
        BK3_OFS_MILLIVOLT: begin
          next_state.rdata = millivolt_word(millivolt);
        end
        default: begin
          next_state.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------

  // frozen while clock enable is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= STATE_RESET;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata = state.rdata;
  assign lightLoadSkipEnable = state.skip;
  assign buck3VoltageCode = state.code;
  assign buck3Millivolt = millivolt;
  assign monitorBlanking = blankActive;
  assign overVoltageFault = state.ovQual;
  assign underVoltageFault = state.uvQual;

endmodule // bk3_control

`default_nettype wire

// file: bk3_pkg.sv
// shared constants, types and helpers of the third buck converter control block
package bk3_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses on the bus)
  // ------------------------------------------------------------
  localparam logic [7:0] BK3_OFS_STATUS = 8'h00;
  localparam logic [7:0] BK3_OFS_MILLIVOLT = 8'h04;
  localparam logic [7:0] BK3_OFS_BUCK3_CONTROL = 8'h18;
  localparam logic [7:0] BK3_OFS_UNMAPPED = 8'hff;

  // ------------------------------------------------------------
  // buck3_control field layout and reset values
  // ------------------------------------------------------------
  localparam int BK3_SKIP_BIT = 7;
  localparam int BK3_RSVD_BIT = 6;
  localparam int BK3_CODE_LSB = 0;
  localparam int BK3_CODE_W = 6;
  localparam logic [7:0] BK3_CONTROL_RESET = 8'hbd;
  localparam logic BK3_SKIP_RESET = 1'h1;
  localparam logic [5:0] BK3_CODE_RESET = 6'h3d;

  // ------------------------------------------------------------
  // status register field layout
  // ------------------------------------------------------------
  localparam int BK3_ST_BLANK_BIT = 0;
  localparam int BK3_ST_UNLOCK_BIT = 1;
  localparam int BK3_ST_REJECT_BIT = 2;
  localparam int BK3_ST_OV_RAW_BIT = 3;
  localparam int BK3_ST_UV_RAW_BIT = 4;
  localparam int BK3_ST_OV_QUAL_BIT = 5;
  localparam int BK3_ST_UV_QUAL_BIT = 6;
  localparam int BK3_ST_WRCNT_LSB = 8;
  localparam int BK3_ST_BADCNT_LSB = 16;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned BK3_CLK_HZ = 40_000_000;
  localparam int unsigned BK3_BLANK_MS = 5;
  localparam int unsigned BK3_BLANK_CYCLES = BK3_BLANK_MS * (BK3_CLK_HZ / 1000);

  // ------------------------------------------------------------
  // voltage code to millivolt mapping
  // ------------------------------------------------------------
  localparam logic [11:0] BK3_FINE_BASE_MV = 12'h384;
  localparam logic [11:0] BK3_FINE_STEP_MV = 12'h019;
  localparam logic [5:0] BK3_FINE_LAST_CODE = 6'h1a;
  localparam logic [11:0] BK3_COARSE_BASE_MV = 12'h640;
  localparam logic [11:0] BK3_COARSE_STEP_MV = 12'h032;
  localparam logic [5:0] BK3_COARSE_FIRST_CODE = 6'h1b;

  // ------------------------------------------------------------
  // bus encodings
  // ------------------------------------------------------------
  localparam logic [2:0] BK3_HSIZE_BYTE = 3'h0;
  localparam logic [2:0] BK3_HSIZE_HALF = 3'h1;
  localparam logic BK3_HRESP_OKAY = 1'h0;

  typedef enum logic {BK3_ST_STRAP, BK3_ST_RUN} bk3_phase_e;

  // converter target in millivolts for a voltage code
  function automatic logic [11:0] bk3_code_to_mv(input logic [5:0] code);
    logic [11:0] mv;
    if (code <= BK3_FINE_LAST_CODE) begin
      mv = BK3_FINE_BASE_MV + 12'(code) * BK3_FINE_STEP_MV;
    end else begin
      mv = BK3_COARSE_BASE_MV + 12'(code - BK3_COARSE_FIRST_CODE) * BK3_COARSE_STEP_MV;
    end
    return mv;
  endfunction

  // true when a transfer of this size and address touches byte lane 0
  function automatic logic bk3_lane0_hit(input logic [2:0] size, input logic [1:0] low);
    logic hit;
    case (size)
      BK3_HSIZE_BYTE: hit = (low == 2'h0);
      BK3_HSIZE_HALF: hit = (low[1] == 1'h0);
      default: hit = 1'h1;
    endcase
    return hit;
  endfunction

endpackage

// file: bk3_blank_timer.sv
// monitor blanking timer started by each accepted control write
`timescale 1ns/1ps
`default_nettype none

module bk3_blank_timer #(
  parameter int unsigned CYCLES = bk3_pkg::BK3_BLANK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic start,
  output logic active
);
  import bk3_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic active;
  } bk3_timer_s;

  bk3_timer_s state;
  bk3_timer_s next_state;

  // restart on every accepted control write, otherwise count down to zero
  always_comb begin
    next_state = state;
    if (start) begin
      next_state.count = CW'(CYCLES);
    end else if (state.count != '0) begin
      next_state.count = state.count - CW'(1);
    end
    next_state.active = (next_state.count != '0);
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  assign active = state.active;

endmodule // bk3_blank_timer

`default_nettype wire

// file: bk3_code_decode.sv
// registered millivolt target of the buck voltage code
`timescale 1ns/1ps
`default_nettype none

module bk3_code_decode (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [5:0] code,
  output logic [11:0] millivolt
);
  import bk3_pkg::*;

  typedef struct packed {
    logic [11:0] mv;
  } bk3_decode_s;

  bk3_decode_s state;
  bk3_decode_s next_state;

  // two-slope mapping, fine steps low and coarse steps high
  always_comb begin
    next_state = state;
    next_state.mv = bk3_code_to_mv(code);
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  assign millivolt = state.mv;

endmodule // bk3_code_decode

`default_nettype wire

// file: bk3_control_sva.sv
// checker of the buck3 control register bus, write guard and monitor blanking
`timescale 1ns/1ps
`default_nettype none

module bk3_control_sva #(
  parameter int unsigned BLANK_CYCLES = bk3_pkg::BK3_BLANK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic writeUnlock,
  input wire logic overVoltageRaw,
  input wire logic lightLoadSkipEnable,
  input wire logic [5:0] buck3VoltageCode,
  input wire logic monitorBlanking,
  input wire logic overVoltageFault,
  input wire logic underVoltageFault
);
  import bk3_pkg::*;
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  logic take;
  logic wrAcc;
  logic wrPend;
  logic rdPend;
  logic [31:0] cnt;
  // control transfer taken, and the data phase edge of an unlocked write
  assign take = clkEn && hsel && htrans[1] && hready && haddr == {24'h0, BK3_OFS_BUCK3_CONTROL};
  assign wrAcc = wrPend && writeUnlock && clkEn && hready;
  // pending data phases and edges since the last accepted write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend <= 1'h0;
      rdPend <= 1'h0;
      cnt <= '1;
    end else begin
      if (clkEn && hready) begin
        wrPend <= take && hwrite;
        rdPend <= take && !hwrite;
      end
      if (wrAcc) begin
        cnt <= '0;
      end else if (cnt != '1) begin
        cnt <= cnt + 32'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_ctl_write;
    wrAcc;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_write_takes: assert property (s_ctl_write |=>
    buck3VoltageCode == $past(hwdata[5:0]) && lightLoadSkipEnable == $past(hwdata[7]))
    else $error("accepted write not applied");
  a_locked_hold: assert property (wrPend && !writeUnlock && hready |=>
    $stable(buck3VoltageCode) && $stable(lightLoadSkipEnable))
    else $error("locked write changed the register");
  a_ctl_read: assert property (rdPend |->
    hrdata == {24'h0, lightLoadSkipEnable, 1'h0, buck3VoltageCode})
    else $error("control read data wrong");
  a_blank_start: assert property (s_ctl_write |=> monitorBlanking)
    else $error("blanking not started");
  a_blank_hold: assert property (cnt < BLANK_CYCLES - 1 |-> monitorBlanking)
    else $error("blanking ended early");
  a_blank_end: assert property (cnt > BLANK_CYCLES + 1 |-> !monitorBlanking)
    else $error("blanking lasts too long");
  a_fault_masked: assert property (monitorBlanking && $past(monitorBlanking) |->
    !overVoltageFault && !underVoltageFault)
    else $error("fault shown while blanked");
  a_fault_passes: assert property (!monitorBlanking && !$past(monitorBlanking) &&
    !$past(monitorBlanking, 2) |-> overVoltageFault == $past(overVoltageRaw))
    else $error("fault not following comparator");
endmodule // bk3_control_sva

bind bk3_control bk3_control_sva #(.BLANK_CYCLES(BLANK_CYCLES)) bk3_control_sva_inst (.*);

`default_nettype wire

// file: tb.sv
// self-checking bench of the buck3 control register block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import bk3_pkg::*;
  localparam int unsigned BLANK = 20;
  logic clk, arst_n, clkEn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, d, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic writeUnlock, resistorDefaultSelect, overVoltageRaw, underVoltageRaw;
  logic [5:0] resistorDefaultCode, buck3VoltageCode;
  logic lightLoadSkipEnable, monitorBlanking, overVoltageFault, underVoltageFault;
  logic [11:0] buck3Millivolt;
  logic [7:0] ctl;
  logic [5:0] edgeCodes [4] = '{6'h00, 6'h1a, 6'h1b, 6'h3f};
  int failures = 0;
  int numChecks = 0;

  bk3_control #(.BLANK_CYCLES(BLANK)) bk3_control_inst (.clk, .arst_n, .clkEn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .writeUnlock,
    .resistorDefaultSelect, .resistorDefaultCode, .overVoltageRaw, .underVoltageRaw,
    .lightLoadSkipEnable, .buck3VoltageCode, .buck3Millivolt, .monitorBlanking,
    .overVoltageFault, .underVoltageFault);

  // ------------------------------------------------------------
  // clock, bus ready and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  assign hready = hreadyout;
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end

  // ------------------------------------------------------------
  // tasks and model
  // ------------------------------------------------------------
  task automatic results();
    if (failures == 0 && numChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    numChecks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  function automatic logic [31:0] mv(input logic [5:0] c);
    return (c <= 26) ? 900 + 25 * c : 1600 + 50 * (c - 27);
  endfunction
  // read back the control word and the converter outputs
  task automatic chkCtl();
    xfer({24'h0, BK3_OFS_BUCK3_CONTROL}, 1'h0, 32'h0, r);
    check("control", r, {24'h0, ctl});
    check("hresp", 32'(hresp), 32'(BK3_HRESP_OKAY));
    check("skip", 32'(lightLoadSkipEnable), 32'(ctl[7]));
    check("code", 32'(buck3VoltageCode), 32'(ctl[5:0]));
    check("millivolt", 32'(buck3Millivolt), mv(ctl[5:0]));
    xfer({24'h0, BK3_OFS_MILLIVOLT}, 1'h0, 32'h0, r);
    check("mvReg", r, mv(ctl[5:0]));
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {arst_n, hwrite, writeUnlock, resistorDefaultSelect, overVoltageRaw, underVoltageRaw} = '0;
    {clkEn, hsel, hsize, haddr, htrans, hwdata, resistorDefaultCode} = {2'h3, 3'h2, 72'h0};
    void'($urandom(66));
    ctl = BK3_CONTROL_RESET;
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    chkCtl();
    xfer({24'h0, BK3_OFS_BUCK3_CONTROL}, 1'h1, $urandom, r);
    chkCtl();
    check("lockBlank", 32'(monitorBlanking), 32'h0);
    xfer({24'h0, BK3_OFS_STATUS}, 1'h0, 32'h0, r);
    check("rejected", 32'(r[BK3_ST_REJECT_BIT]), 32'h1);
    writeUnlock <= 1'h1;
    for (int i = 0; i < 10; i++) begin
      d = $urandom;
      d[6] = 1'h1;
      if (i < 4) d[5:0] = edgeCodes[i];
      xfer({24'h0, BK3_OFS_BUCK3_CONTROL}, 1'h1, d, r);
      ctl = {d[7], 1'h0, d[5:0]};
      chkCtl();
    end
    overVoltageRaw <= 1'h1;
    underVoltageRaw <= 1'h1;
    repeat (2) @(posedge clk);
    check("blanking", 32'(monitorBlanking), 32'h1);
    check("ovFault", 32'({overVoltageFault, underVoltageFault}), 32'h0);
    repeat (BLANK + 4) @(posedge clk);
    check("blankEnd", 32'(monitorBlanking), 32'h0);
    check("ovFault", 32'({overVoltageFault, underVoltageFault}), 32'h3);
    // clock enable low freezes the block and holds the bus off
    clkEn <= 1'h0;
    repeat (2) @(posedge clk);
    check("frozen", 32'({hreadyout, buck3VoltageCode}), 32'({1'h0, ctl[5:0]}));
    clkEn <= 1'h1;
    xfer({24'h0, BK3_OFS_UNMAPPED}, 1'h0, 32'h0, r);
    check("unmapped", r, 32'h0);
    xfer({24'h0, BK3_OFS_UNMAPPED}, 1'h1, 32'hffffffff, r);
    chkCtl();
    overVoltageRaw <= 1'h0;
    underVoltageRaw <= 1'h0;
    resistorDefaultSelect <= 1'h1;
    resistorDefaultCode <= 6'($urandom);
    arst_n <= 1'h0;
    repeat (3) @(posedge clk);
    arst_n <= 1'h1;
    ctl = {2'h2, resistorDefaultCode};
    @(posedge clk);
    chkCtl();
    results();
  end
endmodule // tb

`default_nettype wire
